// ===== core/osc_ctrl.sv
// Contract
// - current source reads 101 low-power rc, 110 fast rc /16, 111 fast rc /n
// - bits 10..8 hold the source the next switch request moves to
// - bit 11 reads zero always
// - bit 1 turns the secondary oscillator on or off
// - writing one to bit 0 switches the clock to the new source
// - bit 0 returns to zero when the switch has finished
// - writes to the control register need an unlock sequence first
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "osc_ctrl_defs.svh"
module osc_ctrl
  import osc_ctrl_pkg::*;
(
  input  wire logic        clk_i,          // system clock, 250 MHz
  input  wire logic        rstn_i,         // async reset, active low
  input  wire logic        wb_cyc_i,       // wishbone cycle
  input  wire logic        wb_stb_i,       // wishbone strobe
  input  wire logic        wb_we_i,        // wishbone write enable
  input  wire logic [7:0]  wb_adr_i,       // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,       // wishbone byte selects
  input  wire logic [31:0] wb_dat_i,       // wishbone write data
  output logic      [31:0] wb_dat_o,       // wishbone read data
  output logic             wb_ack_o,       // wishbone acknowledge
  input  wire logic [2:0]  cfg_src_i,      // power-on source from config bits
  input  wire logic        cfg_lock_en_i,  // config bit allowing clock lock
  input  wire logic        pll_lock_i,     // analog pll lock, asynchronous
  input  wire logic        clk_fail_i,     // fail-safe monitor detect, async
  output logic      [2:0]  clk_sel_o,      // selected system clock source
  output logic             pll_en_o,       // pll power enable
  output logic             sec_osc_en_o,   // secondary oscillator enable
  output logic             irq_o           // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and pll lock status

  logic [1:0] async_sync;
  logic       pll_locked;

  pin_sync #(.W(2)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({pll_lock_i, clk_fail_i}),
    .q_o    (async_sync)
  );

  pll_lock_timer u_lock (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .pll_en_i   (pll_en_o),
    .pll_lock_i (async_sync[1]),
    .locked_o   (pll_locked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        req;
  logic        wr;
  logic [15:0] wdat;

  assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr   = req && wb_we_i;
  assign wdat = wb_dat_i[15:0];

  function automatic logic hit(input logic [7:0] ofs);
    hit = (wb_adr_i == ofs);
  endfunction

  // low two lanes must both be selected for a 16-bit register write
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr && hit(ofs) && (wb_sel_i[1:0] == 2'h3);
  endfunction

  function automatic logic is_pll_src(input logic [2:0] s);
    is_pll_src = (s == SRC_FAST_RC_PLL) || (s == SRC_PRIMARY_PLL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence: key1 then key2 opens one write to the control register

  unlock_state_t ul_ff;
  logic          ctrl_wr;

  assign ctrl_wr = wr_hit(`OSC_CTRL_OFS) && (ul_ff == UL_OPEN);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ul_ff <= UL_IDLE;
    end else if (wr_hit(`OSC_UNLOCK_OFS)) begin
      unique case (ul_ff)
        UL_IDLE: ul_ff <= (wdat == `UNLOCK_KEY1) ? UL_KEY1 : UL_IDLE;
        UL_KEY1: ul_ff <= (wdat == `UNLOCK_KEY2) ? UL_OPEN : UL_IDLE;
        UL_OPEN: ul_ff <= (wdat == `UNLOCK_KEY1) ? UL_KEY1 : UL_IDLE;
        default: ul_ff <= UL_IDLE;
      endcase
    end else if (wr) begin
      // any other write, accepted or not, closes the window
      ul_ff <= UL_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on capture of the configured source

  logic boot_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_ff <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control fields

  logic [2:0] new_src_ff;
  logic       cfg_lock_ff;
  logic       sw_req_ff;
  logic       clk_fail_ff;
  logic       sw_done;
  logic       sw_start;
  logic       fail_evt;

  // once locked, source selection is frozen
  assign sw_start = ctrl_wr && wdat[`SWITCH_REQ_BIT] && !sw_req_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      new_src_ff <= 3'h0;
    end else if (boot_ff) begin
      new_src_ff <= cfg_src_i;
    end else if (ctrl_wr && !cfg_lock_ff && !sw_req_ff) begin
      new_src_ff <= wdat[`NEW_SRC_HI:`NEW_SRC_LO];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_lock_ff <= 1'b0;
    end else if (ctrl_wr && cfg_lock_en_i) begin
      cfg_lock_ff <= wdat[`CFG_LOCK_BIT] | cfg_lock_ff;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sec_osc_en_o <= 1'b0;
    end else if (ctrl_wr) begin
      sec_osc_en_o <= wdat[`SEC_OSC_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sw_req_ff <= 1'b0;
    end else if (sw_done) begin
      sw_req_ff <= 1'b0;
    end else if (sw_start && !cfg_lock_ff) begin
      sw_req_ff <= 1'b1;
    end
  end

  assign fail_evt = async_sync[0];

  // monitor detect wins over a software clear in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_fail_ff <= 1'b0;
    end else if (fail_evt) begin
      clk_fail_ff <= 1'b1;
    end else if (ctrl_wr && !wdat[`CLK_FAIL_BIT]) begin
      clk_fail_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switch sequencer

  sw_state_t  sw_ff;
  logic [2:0] settle_ff;
  logic       illegal_sw;

  // a direct pll-to-pll move is refused: request clears, source stays
  assign illegal_sw = is_pll_src(clk_sel_o) && is_pll_src(new_src_ff) &&
                      (clk_sel_o != new_src_ff);
  assign sw_done    = (sw_ff == SW_DONE);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sw_ff     <= SW_IDLE;
      settle_ff <= 3'h0;
    end else begin
      unique case (sw_ff)
        SW_IDLE: begin
          if (sw_req_ff) begin
            sw_ff     <= SW_SETTLE;
            settle_ff <= 3'h0;
          end
        end
        SW_SETTLE: begin
          if (illegal_sw || settle_ff == 3'(`SWITCH_SETTLE_CYC - 1)) begin
            sw_ff <= SW_DONE;
          end else begin
            settle_ff <= settle_ff + 3'h1;
          end
        end
        SW_DONE: sw_ff <= SW_IDLE;
        default: sw_ff <= SW_IDLE;
      endcase
    end
  end

  // after the power-on capture, current source only changes at the end of a legal switch
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_sel_o <= 3'h0;
    end else if (boot_ff) begin
      clk_sel_o <= cfg_src_i;
    end else if (sw_ff == SW_SETTLE && !illegal_sw &&
                 settle_ff == 3'(`SWITCH_SETTLE_CYC - 1)) begin
      clk_sel_o <= new_src_ff;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pll_en_o <= 1'b0;
    end else begin
      pll_en_o <= is_pll_src(clk_sel_o) || (sw_req_ff && is_pll_src(new_src_ff));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  logic [`IRQ_W-1:0] irq_stat_ff;
  logic [`IRQ_W-1:0] irq_en_ff;
  logic [`IRQ_W-1:0] irq_evt;
  logic [`IRQ_W-1:0] irq_clr;
  logic              lock_d_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_d_ff <= 1'b0;
    end else begin
      lock_d_ff <= pll_locked;
    end
  end

  always_comb begin
    irq_evt                    = '0;
    irq_evt[`IRQ_SWITCH_DONE]  = sw_done;
    irq_evt[`IRQ_CLK_FAIL]     = fail_evt && !clk_fail_ff;
    irq_evt[`IRQ_PLL_LOCK]     = pll_locked && !lock_d_ff;
  end

  assign irq_clr = wr_hit(`OSC_IRQ_CLR_OFS) ? wdat[`IRQ_W-1:0] : '0;

  // set beats clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_en_ff <= '0;
    end else if (wr_hit(`OSC_IRQ_EN_OFS)) begin
      irq_en_ff <= wdat[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_stat_ff & ~irq_clr) | irq_evt) & irq_en_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge

  logic [15:0] ctrl_rd;
  logic [31:0] nxt_rdat;

  always_comb begin
    ctrl_rd                            = 16'h0000;
    ctrl_rd[`CUR_SRC_HI:`CUR_SRC_LO]   = clk_sel_o;
    ctrl_rd[`NEW_SRC_HI:`NEW_SRC_LO]   = new_src_ff;
    ctrl_rd[`CFG_LOCK_BIT]             = cfg_lock_ff;
    ctrl_rd[`PLL_LOCK_BIT]             = pll_locked;
    ctrl_rd[`CLK_FAIL_BIT]             = clk_fail_ff;
    ctrl_rd[`SEC_OSC_EN_BIT]           = sec_osc_en_o;
    ctrl_rd[`SWITCH_REQ_BIT]           = sw_req_ff;
  end

  always_comb begin
    nxt_rdat = 32'h0000_0000;
    if (hit(`OSC_CTRL_OFS)) begin
      nxt_rdat = {16'h0000, ctrl_rd};
    end else if (hit(`OSC_IRQ_STAT_OFS)) begin
      nxt_rdat = {{(32-`IRQ_W){1'b0}}, irq_stat_ff};
    end else if (hit(`OSC_IRQ_EN_OFS)) begin
      nxt_rdat = {{(32-`IRQ_W){1'b0}}, irq_en_ff};
    end
  end

  // unmapped addresses ack with zero data; writes there are dropped
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? nxt_rdat : 32'h0000_0000;
    end
  end

endmodule

// ===== inc/osc_ctrl_defs.svh
`ifndef OSC_CTRL_DEFS_SVH
`define OSC_CTRL_DEFS_SVH

// register byte offsets
`define OSC_CTRL_OFS      8'h00
`define OSC_UNLOCK_OFS    8'h04
`define OSC_IRQ_STAT_OFS  8'h08
`define OSC_IRQ_EN_OFS    8'h0c
`define OSC_IRQ_CLR_OFS   8'h10

// field positions of the control register
`define CUR_SRC_HI        14
`define CUR_SRC_LO        12
`define NEW_SRC_HI        10
`define NEW_SRC_LO        8
`define CFG_LOCK_BIT      7
`define PLL_LOCK_BIT      5
`define CLK_FAIL_BIT      3
`define SEC_OSC_EN_BIT    1
`define SWITCH_REQ_BIT    0

// unlock sequence keys, written one after the other to the unlock register
`define UNLOCK_KEY1       16'h0046
`define UNLOCK_KEY2       16'h0057

// timing
`define PLL_START_NS      2000
`define CLK_PERIOD_NS     4
`define PLL_START_CYC     ((`PLL_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SWITCH_SETTLE_CYC 4

// interrupt status bit positions
`define IRQ_SWITCH_DONE   0
`define IRQ_CLK_FAIL      1
`define IRQ_PLL_LOCK      2
`define IRQ_W             3

`endif

// ===== inc/osc_ctrl_pkg.sv
package osc_ctrl_pkg;

  typedef enum logic [2:0] {
    SRC_FAST_RC      = 3'h0,
    SRC_FAST_RC_PLL  = 3'h1,
    SRC_PRIMARY      = 3'h2,
    SRC_PRIMARY_PLL  = 3'h3,
    SRC_SECONDARY    = 3'h4,
    SRC_LOW_POWER_RC = 3'h5,
    SRC_FAST_RC_D16  = 3'h6,
    SRC_FAST_RC_DN   = 3'h7
  } osc_src_t;

  typedef enum logic [1:0] {
    SW_IDLE   = 2'b00,
    SW_SETTLE = 2'b01,
    SW_DONE   = 2'b11
  } sw_state_t;

  typedef enum logic [1:0] {
    UL_IDLE  = 2'b00,
    UL_KEY1  = 2'b01,
    UL_OPEN  = 2'b11
  } unlock_state_t;

endpackage

// ===== core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,   // system clock
  input  wire logic         rstn_i,  // async reset, active low
  input  wire logic [W-1:0] d_i,     // asynchronous input
  output logic      [W-1:0] q_o      // synchronised output
);
  logic [W-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= '0;
      q_o     <= '0;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule

// ===== core/pll_lock_timer.sv
`timescale 1ns/1ps
`include "osc_ctrl_defs.svh"
module pll_lock_timer #(
  parameter int START_CYC = `PLL_START_CYC
) (
  input  wire logic clk_i,      // system clock
  input  wire logic rstn_i,     // async reset, active low
  input  wire logic pll_en_i,   // pll power enable
  input  wire logic pll_lock_i, // synchronised analog lock
  output logic      locked_o    // lock status
);
  logic [15:0] cnt_ff;
  logic        expired;

  assign expired = (cnt_ff == 16'(START_CYC));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 16'h0000;
    end else if (!pll_en_i) begin
      cnt_ff <= 16'h0000;
    end else if (!expired) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // reads one only when enabled and both locked and past start-up
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      locked_o <= 1'b0;
    end else begin
      locked_o <= pll_en_i && pll_lock_i && expired;
    end
  end
endmodule

// ===== tb/osc_ctrl_assertions.sv
`timescale 1ns/1ps
module osc_ctrl_chk
  import osc_ctrl_pkg::*;
(
  input wire logic        clk_i,         // clock
  input wire logic        rstn_i,        // reset
  input wire logic        wb_cyc_i,      // cycle
  input wire logic        wb_stb_i,      // strobe
  input wire logic        wb_we_i,       // write
  input wire logic [7:0]  wb_adr_i,      // address
  input wire logic [3:0]  wb_sel_i,      // selects
  input wire logic [31:0] wb_dat_i,      // wr data
  input wire logic [31:0] wb_dat_o,      // rd data
  input wire logic        wb_ack_o,      // ack
  input wire logic [2:0]  cfg_src_i,     // cfg source
  input wire logic        cfg_lock_en_i, // cfg lock
  input wire logic        pll_lock_i,    // pll lock
  input wire logic        clk_fail_i,    // fail detect
  input wire logic [2:0]  clk_sel_o,     // source
  input wire logic        pll_en_o,      // pll enable
  input wire logic        sec_osc_en_o,  // sec osc
  input wire logic        irq_o          // irq
);
  wire rd_ctl = wb_ack_o && !wb_we_i && wb_adr_i == 8'h00;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  unmapped_zero_a: assert property (wb_ack_o && wb_adr_i > 8'h10 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  unused_bits_a: assert property (rd_ctl |-> !wb_dat_o[15] && !wb_dat_o[11])
    else $error("unused control bit set");
  cur_source_a: assert property (rd_ctl |-> wb_dat_o[14:12] == $past(clk_sel_o))
    else $error("current source field wrong");
  sec_osc_a: assert property (rd_ctl |-> wb_dat_o[1] == $past(sec_osc_en_o))
    else $error("secondary enable mismatch");
  no_pll_hop_a: assert property (!($past(clk_sel_o) == 3'h1 && clk_sel_o == 3'h3) &&
    !($past(clk_sel_o) == 3'h3 && clk_sel_o == 3'h1)) else $error("direct pll switch");
  irq_off_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h0c &&
    wb_dat_i[2:0] == 3'h0 |-> ##[0:2] !irq_o) else $error("irq with none enabled");
  sw_cov: cover property (clk_sel_o != $past(clk_sel_o));
  irq_cov: cover property ($rose(irq_o));
  rd_cov: cover property (rd_ctl);
endmodule
bind osc_ctrl osc_ctrl_chk osc_ctrl_chk_inst (.clk_i(clk_i), .rstn_i(rstn_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cfg_src_i(cfg_src_i), .cfg_lock_en_i(cfg_lock_en_i), .pll_lock_i(pll_lock_i),
  .clk_fail_i(clk_fail_i), .clk_sel_o(clk_sel_o), .pll_en_o(pll_en_o),
  .sec_osc_en_o(sec_osc_en_o), .irq_o(irq_o));

// ===== tb/tb_osc_ctrl.sv
`timescale 1ns/1ps
module tb_osc_ctrl;
  logic        clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, pll_lock_i, clk_fail_i;
  logic        wb_ack_o, pll_en_o, sec_osc_en_o, irq_o, sec, cfg_lock_en_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [2:0]  cfg_src_i, clk_sel_o, s, en;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [2:0]  srcs[3];
  int          num_errors, check_count, seed, n, i;
  localparam logic [31:0] M = 32'h0000ff0b;

  osc_ctrl osc_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cfg_src_i(cfg_src_i), .cfg_lock_en_i(cfg_lock_en_i), .pll_lock_i(pll_lock_i),
    .clk_fail_i(clk_fail_i), .clk_sel_o(clk_sel_o), .pll_en_o(pll_en_o),
    .sec_osc_en_o(sec_osc_en_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////
  task complete_run;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task compare_data(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    check_count++;
    if ((got & m) !== (e & m)) begin
      num_errors++;
      $display("MISMATCH %0t data %h expected %h", $time, got, e);
    end
  endtask

  task compare_bit(input logic got, input logic e);
    check_count++;
    if (got !== e) begin
      num_errors++;
      $display("MISMATCH %0t output %b expected %b", $time, got, e);
    end
  endtask

  task fail(input int c);
    if (c != 0) begin
      num_errors++;
      $display("MISMATCH %0t wait ran out", $time);
      complete_run;
    end
  endtask

  // read results are judged here, in the order the reads were issued
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      compare_data(wb_dat_o, exp_q.pop_front(), msk_q.pop_front());
  end
  ////////////////////////////////////////////////////////////////
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    fail(n >= 40);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  // this task precedes its control write with the two unlock keys
  task ul(input logic [2:0] src, input logic r);
    bus(1'b1, 8'h04, 32'h0046);
    bus(1'b1, 8'h04, 32'h0057);
    bus(1'b1, 8'h00, {21'h0, src, 6'h0, sec, r});
  endtask

  task wt;
    i = 0;
    do begin
      rd(8'h00, 32'h0, 32'hffff8854);
      i++;
    end while (q[0] !== 1'b0 && i < 300);
    fail(i >= 300);
  endtask

  function logic [31:0] cx(input logic [2:0] c, input logic [2:0] nw);
    cx = {17'h0, c, 1'b0, nw, 6'h0, sec, 1'b0};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    rstn_i = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 8'h0; wb_sel_i = 4'hf; wb_dat_i = 32'h0; cfg_src_i = 3'h5;
    pll_lock_i = 1'b0; clk_fail_i = 1'b0; sec = 1'b0; seed = 59;
    cfg_lock_en_i = 1'b0;
    num_errors = 0; check_count = 0;
    srcs = '{3'h6, 3'h7, 3'h5};
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(8'h00, cx(3'h5, 3'h5), M);
    bus(1'b1, 8'h00, 32'h0502);
    rd(8'h00, cx(3'h5, 3'h5), M);
    compare_bit(sec_osc_en_o, 1'b0);
    sec = 1'b1;
    ul(3'h5, 1'b0);
    repeat (2) @(posedge clk_i);
    compare_bit(sec_osc_en_o, 1'b1);
    en = 3'h1 | (3'($random(seed)) & 3'h6);
    bus(1'b1, 8'h0c, {29'h0, en});
    for (int k = 0; k < 3; k++) begin
      s = srcs[k];
      ul(s, 1'b1);
      rd(8'h00, 32'h1, 32'h1);
      wt;
      rd(8'h00, cx(s, s), M);
      compare_data({29'h0, clk_sel_o}, {29'h0, s}, 32'h7);
      compare_bit(irq_o, 1'b1);
      rd(8'h08, 32'h1, 32'h1);
      bus(1'b1, 8'h10, 32'h7);
      repeat (2) @(posedge clk_i);
      compare_bit(irq_o, 1'b0);
    end
    ul(3'h1, 1'b1);
    rd(8'h00, 32'h0, 32'h20);
    pll_lock_i <= 1'b1;
    wt;
    repeat (520) @(posedge clk_i);
    rd(8'h00, cx(3'h1, 3'h1) | 32'h20, M | 32'h20);
    compare_bit(pll_en_o, 1'b1);
    ul(3'h3, 1'b1);
    wt;
    rd(8'h00, 32'h1000, 32'h7000);
    ul(3'h0, 1'b1);
    wt;
    ul(3'h3, 1'b1);
    wt;
    rd(8'h00, cx(3'h3, 3'h3), M);
    clk_fail_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    clk_fail_i <= 1'b0;
    rd(8'h00, 32'h8, 32'h8);
    repeat (10) @(posedge clk_i);
    rd(8'h00, 32'h8, 32'h8);
    ul(clk_sel_o, 1'b0);
    rd(8'h00, 32'h0, 32'h8);
    rd(8'h20, 32'h0, 32'hffffffff);
    // lock the selection, then a switch request must leave both source fields alone
    cfg_lock_en_i <= 1'b1;
    bus(1'b1, 8'h04, 32'h0046);
    bus(1'b1, 8'h04, 32'h0057);
    bus(1'b1, 8'h00, 32'h0380);
    ul(3'h0, 1'b1);
    rd(8'h00, cx(3'h3, 3'h3) | 32'h80, M | 32'h80);
    bus(1'b1, 8'h0c, 32'h0);
    repeat (4) @(posedge clk_i);
    complete_run;
  end
endmodule
